// File: rtl/acmp_top.sv
`timescale 1ns/10ps
`include "acmp_regs.svh"
module acmp_top #(
    parameter bit HAS_PIN_OUT = 1'b1 // Instance offers the pin output
) (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic cmp_decision, // Analog decision, 1 when neg < pos
    output logic [1:0] pos_source_select, // Positive source to analog mux
    output logic ref_enable, // Ladder powered
    output logic span_select, // Ladder span
    output logic [3:0] ref_tap, // Ladder tap
    output logic [4:0] ref_num, // Reference fraction numerator
    output logic [4:0] ref_den, // Reference fraction denominator
    output logic cmp_pin_out, // Result to device pin
    output logic adc_trigger, // Converter sample trigger
    output logic irq, // Interrupt, level, active high
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    import acmp_pkg::*;

    // ****************************************************************
    // Synchroniser and edge detector
    // ****************************************************************
    acmp_edge_if sync_if ();

    acmp_sync_edge u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(cmp_decision),
        .edge_o(sync_if.src)
    );

    // ****************************************************************
    // Bus state
    // ****************************************************************
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;
    logic wr_go;

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [9:0] refctl;
    logic [11:0] ctl;
    logic mask_bit;
    logic raw_irq;
    logic output_level;
    logic [9:0] next_refctl;
    logic [11:0] next_ctl;
    logic next_mask_bit;
    logic next_raw_irq;
    logic next_output_level;
    logic next_irq;
    logic next_trigger;
    logic next_pin;
    logic [4:0] next_ref_num;
    logic [4:0] next_ref_den;

    // Decoded control fields
    logic inv;
    logic result;
    logic res_rise;
    logic res_fall;
    logic irq_evt;
    logic trig_evt;
    logic clr_hit;
    acmp_sense_type isen;
    acmp_sense_type tsen;

    // Pick one event out of level or edges for a given sense setting
    function automatic logic evt_pick(input acmp_sense_type mode,
                                      input logic lvl_sense,
                                      input logic lvl,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            ACMP_SENSE_LEVEL: hit = (lvl == lvl_sense);
            ACMP_SENSE_FALL: hit = fall;
            ACMP_SENSE_RISE: hit = rise;
            ACMP_SENSE_BOTH: hit = rise | fall;
        endcase
        return hit;
    endfunction : evt_pick

    // Inversion swaps the edges so both paths see the same result
    always_comb begin
        inv = ctl[`ACMP_CTL_INV_BIT];
        result = sync_if.level ^ inv;
        res_rise = inv ? sync_if.fall : sync_if.rise;
        res_fall = inv ? sync_if.rise : sync_if.fall;
        isen = acmp_sense_type'(ctl[`ACMP_CTL_ISEN_LSB +: 2]);
        tsen = acmp_sense_type'(ctl[`ACMP_CTL_TSEN_LSB +: 2]);
        irq_evt = evt_pick(isen, ctl[`ACMP_CTL_ISLVL_BIT], result,
                           res_rise, res_fall);
        trig_evt = evt_pick(tsen, ctl[`ACMP_CTL_TSLVL_BIT], result,
                            res_rise, res_fall);
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // Address and data are taken in either order; write waits for both
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        wr_go = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            wr_go = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            unique case (aw_addr)
                `ACMP_OFF_MIS, `ACMP_OFF_RIS, `ACMP_OFF_INTEN,
                `ACMP_OFF_REFCTL, `ACMP_OFF_STAT, `ACMP_OFF_CTL:
                    next_bresp = `ACMP_RESP_OKAY;
                default: next_bresp = `ACMP_RESP_SLVERR;
            endcase
        end
        // Ready stays low while a word is held, which stalls the master
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // Reads answer one cycle after the address is taken
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `ACMP_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                `ACMP_OFF_MIS: next_rdata[`ACMP_IRQ_BIT] = raw_irq & mask_bit;
                `ACMP_OFF_RIS: next_rdata[`ACMP_IRQ_BIT] = raw_irq;
                `ACMP_OFF_INTEN: next_rdata[`ACMP_IRQ_BIT] = mask_bit;
                `ACMP_OFF_REFCTL: next_rdata[9:0] = refctl;
                `ACMP_OFF_STAT:
                    next_rdata[`ACMP_STAT_OLVL_BIT] = output_level;
                `ACMP_OFF_CTL: next_rdata[11:0] = ctl;
                default: next_rresp = `ACMP_RESP_SLVERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    // Register the bus outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Control registers, interrupt and outputs
    // ****************************************************************
    // Byte lanes split the fields; bit 0 of lane 0 clears by writing one
    always_comb begin
        next_refctl = refctl;
        next_ctl = ctl;
        next_mask_bit = mask_bit;
        clr_hit = 1'b0;
        if (wr_go && w_strb[0]) begin
            unique case (aw_addr)
                `ACMP_OFF_MIS: clr_hit = w_data[`ACMP_IRQ_BIT];
                `ACMP_OFF_INTEN:
                    next_mask_bit = w_data[`ACMP_IRQ_BIT];
                `ACMP_OFF_REFCTL: next_refctl[3:0] = w_data[3:0];
                `ACMP_OFF_CTL: next_ctl[7:0] = {w_data[7:1], 1'b0};
                default: next_mask_bit = mask_bit;
            endcase
        end
        if (wr_go && w_strb[1]) begin
            unique case (aw_addr)
                `ACMP_OFF_REFCTL: next_refctl[9:8] = w_data[9:8];
                `ACMP_OFF_CTL: next_ctl[11:8] = w_data[11:8];
                default: next_ctl = next_ctl;
            endcase
        end
        // A new event in the clearing cycle keeps the bit set
        next_raw_irq = irq_evt | (raw_irq & ~clr_hit);
        next_irq = next_raw_irq & next_mask_bit;
        next_output_level = result;
        next_trigger = trig_evt & ctl[`ACMP_CTL_TOEN_BIT];
        next_pin = HAS_PIN_OUT ? result : 1'b0;
    end

    // Ladder: ground when unpowered, otherwise tap (plus 8 on the low span) over ladder length
    always_comb begin
        next_ref_num = 5'd0;
        next_ref_den = `ACMP_LADDER_LO_TOTAL;
        if (!next_refctl[`ACMP_REF_EN_BIT]) begin
            next_ref_num = 5'd0;
        end else if (!next_refctl[`ACMP_REF_SPAN_BIT]) begin
            next_ref_num = {1'b0, next_refctl[3:0]}
                + `ACMP_LADDER_LO_OFFSET;
            next_ref_den = `ACMP_LADDER_LO_TOTAL;
        end else begin
            next_ref_num = {1'b0, next_refctl[3:0]};
            next_ref_den = `ACMP_LADDER_HI_TOTAL;
        end
    end

    // Register control and every block output except the bus outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            refctl <= `ACMP_RST_REFCTL;
            ctl <= `ACMP_RST_CTL;
            mask_bit <= `ACMP_RST_MASK;
            raw_irq <= 1'b0;
            output_level <= 1'b0;
            irq <= 1'b0;
            adc_trigger <= 1'b0;
            cmp_pin_out <= 1'b0;
            ref_num <= 5'd0;
            ref_den <= `ACMP_LADDER_LO_TOTAL;
            pos_source_select <= 2'b00;
            ref_enable <= 1'b0;
            span_select <= 1'b0;
            ref_tap <= 4'h0;
        end else begin
            refctl <= next_refctl;
            ctl <= next_ctl;
            mask_bit <= next_mask_bit;
            raw_irq <= next_raw_irq;
            output_level <= next_output_level;
            irq <= next_irq;
            adc_trigger <= next_trigger;
            cmp_pin_out <= next_pin;
            ref_num <= next_ref_num;
            ref_den <= next_ref_den;
            pos_source_select <= next_ctl[`ACMP_CTL_SRC_LSB +: 2];
            ref_enable <= next_refctl[`ACMP_REF_EN_BIT];
            span_select <= next_refctl[`ACMP_REF_SPAN_BIT];
            ref_tap <= next_refctl[3:0];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_irq_mask;
        @(posedge clk_sys) disable iff (rst)
        irq == (raw_irq && mask_bit);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt differs from raw and enable");

    property p_ref_off;
        @(posedge clk_sys) disable iff (rst)
        !ref_enable |-> ref_num == 5'd0;
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("reference not ground while ladder is off");

    property p_ref_lo;
        @(posedge clk_sys) disable iff (rst)
        ref_enable && !span_select |->
            ref_num == ref_tap + 5'd8 && ref_den == 5'd31;
    endproperty
    a_ref_lo: assert property (p_ref_lo)
        else $error("low span fraction wrong");

    property p_ref_hi;
        @(posedge clk_sys) disable iff (rst)
        ref_enable && span_select |->
            ref_num == {1'b0, ref_tap} && ref_den == 5'd23;
    endproperty
    a_ref_hi: assert property (p_ref_hi)
        else $error("high span fraction wrong");

    property p_clear;
        @(posedge clk_sys) disable iff (rst)
        clr_hit && !irq_evt |=> !raw_irq && !irq;
    endproperty
    a_clear: assert property (p_clear)
        else $error("write one did not clear the pending bit");

    property p_rise_sets;
        @(posedge clk_sys) disable iff (rst)
        isen == ACMP_SENSE_RISE && res_rise |=> raw_irq;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising result edge did not set status");

    property p_trigger;
        @(posedge clk_sys) disable iff (rst)
        !ctl[`ACMP_CTL_TOEN_BIT] ##1 !$past(ctl[`ACMP_CTL_TOEN_BIT])
            |-> !adc_trigger;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger fired while disabled");

    property p_level;
        @(posedge clk_sys) disable iff (rst)
        $stable(ctl) |=> output_level == $past(result);
    endproperty
    a_level: assert property (p_level)
        else $error("output level does not follow the result");

    property p_enable_path;
        @(posedge clk_sys) disable iff (rst)
        mask_bit && raw_irq |-> irq;
    endproperty
    a_enable_path: assert property (p_enable_path)
        else $error("enabled pending event missing on interrupt");

endmodule : acmp_top

// File: include/acmp_regs.svh
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ACMP_ADDR_W 12
`define ACMP_OFF_MIS 12'h000
`define ACMP_OFF_RIS 12'h004
`define ACMP_OFF_INTEN 12'h008
`define ACMP_OFF_REFCTL 12'h010
`define ACMP_OFF_STAT 12'h020
`define ACMP_OFF_CTL 12'h024

// ****************************************************************
// Field positions
// ****************************************************************
`define ACMP_IRQ_BIT 0
`define ACMP_REF_EN_BIT 9
`define ACMP_REF_SPAN_BIT 8
`define ACMP_REF_TAP_LSB 0
`define ACMP_TAP_W 4
`define ACMP_STAT_OLVL_BIT 1
`define ACMP_CTL_TOEN_BIT 11
`define ACMP_CTL_SRC_LSB 9
`define ACMP_CTL_TSLVL_BIT 7
`define ACMP_CTL_TSEN_LSB 5
`define ACMP_CTL_ISEN_LSB 3
`define ACMP_CTL_ISLVL_BIT 2
`define ACMP_CTL_INV_BIT 1

// ****************************************************************
// Reset values and ladder counts
// ****************************************************************
`define ACMP_RST_REFCTL 10'h000
`define ACMP_RST_CTL 12'h000
`define ACMP_RST_MASK 1'b0
`define ACMP_LADDER_LO_TOTAL 5'd31
`define ACMP_LADDER_HI_TOTAL 5'd23
`define ACMP_LADDER_LO_OFFSET 5'd8
`define ACMP_RESP_OKAY 2'b00
`define ACMP_RESP_SLVERR 2'b10

`endif

// File: include/acmp_pkg.sv
package acmp_pkg;

    // Positive input source choice
    typedef enum logic [1:0] {
        ACMP_SRC_PIN = 2'b00,
        ACMP_SRC_CMP0 = 2'b01,
        ACMP_SRC_REF = 2'b10,
        ACMP_SRC_RSVD = 2'b11
    } acmp_src_type;

    // Event sense for interrupt and trigger
    typedef enum logic [1:0] {
        ACMP_SENSE_LEVEL = 2'b00,
        ACMP_SENSE_FALL = 2'b01,
        ACMP_SENSE_RISE = 2'b10,
        ACMP_SENSE_BOTH = 2'b11
    } acmp_sense_type;

endpackage : acmp_pkg

// File: include/acmp_edge_if.sv
`timescale 1ns/10ps
// Synchronised result and its edges, one clock domain
interface acmp_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : acmp_edge_if

// File: rtl/acmp_sync_edge.sv
`timescale 1ns/10ps
module acmp_sync_edge (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic async_in, // Raw comparator decision
    acmp_edge_if.src edge_o // Synchronised level and edges
);
    logic meta;
    logic stage;
    logic prev;
    logic next_meta;
    logic next_stage;
    logic next_prev;

    // Only the second stage reads the first; edges come after the second
    always_comb begin
        next_meta = async_in;
        next_stage = meta;
        next_prev = stage;
    end

    // Register the synchroniser chain
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            stage <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= next_meta;
            stage <= next_stage;
            prev <= next_prev;
        end
    end

    // Edges compare settled stage against its own history
    assign edge_o.level = stage;
    assign edge_o.rise = stage & ~prev;
    assign edge_o.fall = ~stage & prev;

    property p_sync_delay;
        @(posedge clk_sys) disable iff (rst)
        edge_o.rise |-> $past(async_in, 2) && !$past(stage);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("rise seen without a synchronised input edge");

endmodule : acmp_sync_edge

// File: verif/acmp_ana_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Analog side: comparator inputs and converter trigger
// ****************************************************************
module acmp_ana_model #(
    parameter int SUPPLY_MV = 3300 // Analog supply in millivolts
) (
    input wire logic [1:0] pos_source_select, // Positive source
    input wire logic ref_enable, // Ladder powered
    input wire logic [4:0] ref_num, // Fraction numerator
    input wire logic [4:0] ref_den, // Fraction denominator
    input wire logic adc_trigger, // Converter trigger
    input wire logic [15:0] neg_mv, // Negative pin voltage
    input wire logic [15:0] pin_mv, // Positive pin voltage
    input wire logic [15:0] cmp0_mv, // Comparator 0 positive input
    output logic cmp_decision, // Decision to the block
    output int trig_count // Trigger pulses seen
);
    import acmp_pkg::*;
    int pos_mv;
    // Zero denominator guarded so a bad ladder code reads as ground
    always_comb begin
        case (acmp_src_type'(pos_source_select))
            ACMP_SRC_PIN: pos_mv = pin_mv;
            ACMP_SRC_CMP0: pos_mv = cmp0_mv;
            default: begin
                pos_mv = 0;
                if (ref_enable && ref_den != 5'h00) begin
                    pos_mv = SUPPLY_MV * ref_num / ref_den;
                end
            end
        endcase
        cmp_decision = (neg_mv < pos_mv);
    end
    // Converter counts sample starts
    initial trig_count = 0;
    always @(posedge adc_trigger) trig_count <= trig_count + 1;
endmodule : acmp_ana_model

// File: verif/testbench.sv
`timescale 1ns/10ps
// ****************************************************************
// Register and event checks
// ****************************************************************
module testbench;
    import acmp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cmp_decision, ref_enable, span_select, cmp_pin_out, adc_trigger;
    logic irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] pos_source_select, s_axi_bresp, s_axi_rresp;
    logic [3:0] ref_tap, s_axi_wstrb;
    logic [4:0] ref_num, ref_den;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [15:0] neg_mv, pin_mv, cmp0_mv;
    logic [33:0] exp_q[$];
    int n_fail = 0;
    int comparisons = 0;
    int trig_count, t0, k;
    // Clock, 4 ns period
    always #2 clk_sys = ~clk_sys;
    acmp_top dut_u (.clk_sys, .rst, .cmp_decision, .pos_source_select,
        .ref_enable, .span_select, .ref_tap, .ref_num, .ref_den, .cmp_pin_out,
        .adc_trigger, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    acmp_ana_model ana_u (.pos_source_select, .ref_enable, .ref_num,
        .ref_den, .adc_trigger, .neg_mv, .pin_mv, .cmp0_mv, .cmp_decision,
        .trig_count);
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input string nm, input logic [33:0] g,
                         input logic [33:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic tmo(input int n);
        if (n >= 50) begin
            n_fail++;
            $display("ERROR handshake expected 1 seen 0");
            end_of_test();
        end
    endtask : tmo
    // Master offers address and data together, drops each when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        int n;
        exp_q.push_back({r, 32'h0});
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        exp_q.push_back(e);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask : axi_rd
    // Two sync flops plus event logic need about three edges
    task automatic settle();
        repeat (8) @(posedge clk_sys);
    endtask : settle
    task automatic wait_irq(input logic v);
        int n;
        for (n = 0; n < 50 && irq !== v; n++) @(negedge clk_sys);
        tmo(n);
    endtask : wait_irq
    // Responses are compared against the oldest note of the driver
    always @(posedge clk_sys) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            check("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            check("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
    end
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        seed = 32'd11661;
        neg_mv = 16'd3000;
        pin_mv = 16'd0;
        cmp0_mv = 16'd0;
        repeat (3) @(posedge clk_sys);
        // Comparator clock counts as gated on before the first access
        rst <= 1'b0;
        axi_rd(12'h024, 34'h0);
        axi_rd(12'h010, 34'h0);
        axi_rd(12'h008, 34'h0);
        axi_rd(12'h0fc, {2'b10, 32'h0});
        axi_wr(12'h0fc, 32'hffff, 2'b10);
        axi_wr(12'h010, 32'h10c, 2'b00);
        @(negedge clk_sys);
        check("ref_num", 34'(ref_num), 34'h0);
        check("ref_tap", 34'(ref_tap), 34'hc);
        // Quietest ground: ladder off, span 1, tap 0
        axi_wr(12'h010, 32'h100, 2'b00);
        @(negedge clk_sys);
        check("span_select", 34'(span_select), 34'h1);
        check("ref_tap", 34'(ref_tap), 34'h0);
        check("ref_enable", 34'(ref_enable), 34'h0);
        check("ref_num", 34'(ref_num), 34'h0);
        // Random taps and spans across both ladder totals
        for (k = 0; k < 6; k++) begin
            seed = xorshift(seed);
            axi_wr(12'h010, {22'h0, 1'b1, seed[4], 4'h0, seed[3:0]}, 2'b00);
            @(negedge clk_sys);
            check("ref_num", 34'(ref_num),
                  34'(seed[3:0]) + (seed[4] ? 34'd0 : 34'd8));
            check("ref_den", 34'(ref_den), seed[4] ? 34'd23 : 34'd31);
            check("ref_tap", 34'(ref_tap), 34'(seed[3:0]));
            check("ref_enable", 34'(ref_enable), 34'h1);
        end
        axi_wr(12'h010, 32'h30c, 2'b00);
        axi_rd(12'h010, 34'h30c);
        axi_wr(12'h024, 32'h40c, 2'b00);
        axi_rd(12'h024, 34'h40c);
        axi_wr(12'h024, 32'hc30, 2'b00);
        // Level sense out of reset left a stale pending bit; clear it first
        axi_wr(12'h000, 32'h1, 2'b00);
        axi_rd(12'h004, 34'h0);
        axi_wr(12'h008, 32'h1, 2'b00);
        settle();
        axi_rd(12'h020, 34'h0);
        t0 = trig_count;
        neg_mv <= 16'd500;
        wait_irq(1'b1);
        check("cmp_pin_out", 34'(cmp_pin_out), 34'h1);
        axi_rd(12'h020, 34'h2);
        axi_rd(12'h004, 34'h1);
        axi_rd(12'h000, 34'h1);
        axi_wr(12'h000, 32'h1, 2'b00);
        wait_irq(1'b0);
        axi_rd(12'h004, 34'h0);
        neg_mv <= 16'd3000;
        settle();
        @(negedge clk_sys);
        check("trig", 34'(trig_count - t0), 34'd1);
        check("irq", 34'(irq), 34'h0);
        axi_wr(12'h008, 32'h0, 2'b00);
        neg_mv <= 16'd500;
        settle();
        @(negedge clk_sys);
        check("irq", 34'(irq), 34'h0);
        axi_rd(12'h004, 34'h1);
        axi_rd(12'h000, 34'h0);
        // Pin source above, comparator 0 source below the negative pin
        pin_mv <= 16'd2000;
        cmp0_mv <= 16'd100;
        axi_wr(12'h024, 32'h0, 2'b00);
        settle();
        axi_rd(12'h020, 34'h2);
        axi_wr(12'h024, 32'h200, 2'b00);
        settle();
        check("pos_source_select", 34'(pos_source_select), 34'h1);
        axi_rd(12'h020, 34'h0);
        // Inverted result: low decision reads back as high
        axi_wr(12'h024, 32'h202, 2'b00);
        settle();
        check("cmp_pin_out", 34'(cmp_pin_out), 34'h1);
        axi_rd(12'h020, 34'h2);
        end_of_test();
    end
endmodule : testbench
